/* File: design/sss_cfg.svh */
`ifndef SSS_CFG_SVH
`define SSS_CFG_SVH

// Oscillator and system clock rates
`define SSS_SYS_FREQ_KHZ     100000
`define SSS_OSC_FREQ_KHZ     100
`define SSS_OSC_DIV          (`SSS_SYS_FREQ_KHZ / `SSS_OSC_FREQ_KHZ)

// Soft-start ramp
`define SSS_RAMP_TICKS       2048
`define SSS_RAMP_SHIFT       11
`define SSS_REF_TARGET_MV    800
`define SSS_UV_EN_MV         600

// Undervoltage must persist longer than one oscillator period
`define SSS_UV_PERSIST_TICKS 2

// On-time limit endpoints in percent of the switching period
`define SSS_TON_ZERO_PCT     80
`define SSS_TON_FS_PCT       40
`define SSS_CUR_FULL_SCALE   255

`endif

/* File: design/sss_pkg.sv */
package sss_pkg;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    SSS_IDLE  = 4'h1,
    SSS_RAMP  = 4'h2,
    SSS_RUN   = 4'h4,
    SSS_FAULT = 4'h8
  } sss_state_t;

  // Reference offset requested by the margining lines
  typedef enum logic [1:0] {
    SSS_MARG_NONE = 2'h0,
    SSS_MARG_POS  = 2'h1,
    SSS_MARG_NEG  = 2'h2
  } sss_margin_t;

  // Asynchronous single-bit pins, synchronised together
  typedef struct packed {
    logic inhibit;
    logic marg_a;
    logic marg_b;
    logic op_mode;
    logic uv_low;
    logic ov_high;
    logic pg_low;
  } sss_pins_t;

endpackage

/* File: design/sss_sync.sv */
`timescale 1ns/1ns
`default_nettype none

module sss_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // Two-stage synchroniser, first stage read only by the second
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

`default_nettype wire

/* File: design/sss_top.sv */
// Operation
// [R1] The reference rises from zero to the target over exactly 2048 oscillator periods.
// [R2] Power-good is held low for the whole ramp and released only when the ramp completes.
// [R3] Undervoltage protection is off early in the ramp and active once the reference is 0.6V.
// [R4] Overvoltage protection stays enabled all through soft-start with a mode-selected level.
// [R5] Soft-start begins only with all supplies good and inhibit released, else stays idle.
// [R6] Low-side drive is kept off during soft-start until the high side first switches.
// [R7] The low-side mask gates loop commands only; overvoltage still forces low-side on.
// [R8] Maximum high-side on-time falls linearly from 0.80 to 0.40 of the period with current.
// [R9] The outside controller selects no offset, positive or negative margin on two lines.
// [R10] Output over 300mV low for more than one period turns all switches off and latches.
// [R11] Overvoltage forces low sides on, high sides off, raises fault and latches.
// [R12] After release power-good is pulled low when output is over 150mV low.
// [R13] A supply or inhibit cycle clears ramp, reference and faults and drops power-good.
`timescale 1ns/1ns
`default_nettype none
`include "sss_cfg.svh"

module sss_top
  import sss_pkg::*;
#(
  parameter int NPH     = 3,
  parameter int NSUP    = 2,
  parameter int OSC_DIV = `SSS_OSC_DIV
) (
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  input  wire logic [NSUP-1:0]      supply_ok_in,
  input  wire logic                 inhibit_in,
  input  wire logic                 margin_sel_a,
  input  wire logic                 margin_sel_b,
  input  wire logic                 op_mode_in,
  input  wire logic                 uv_cmp_in,
  input  wire logic                 ov_cmp_in,
  input  wire logic                 pg_cmp_in,
  input  wire logic [NPH-1:0]       hs_cmd,
  input  wire logic [NPH-1:0]       ls_cmd,
  input  wire logic [NPH-1:0][7:0]  phase_cur,
  output logic      [NPH-1:0]       high_side_drive,
  output logic      [NPH-1:0]       low_side_drive,
  output logic                      power_ok_out,
  output logic                      power_ok_oe,
  output logic                      fault_out,
  output logic                      undervoltage_trip,
  output logic                      overvoltage_trip,
  output logic                      uv_enable,
  output logic                      ov_level_sel,
  output logic                      ramp_done,
  output logic      [9:0]           ref_mv,
  output sss_margin_t               margin_mode
);

  localparam logic [11:0] RAMP_END  = 12'(`SSS_RAMP_TICKS);
  localparam logic [9:0]  TARGET_MV = 10'(`SSS_REF_TARGET_MV);
  localparam logic [9:0]  UV_EN_MV  = 10'(`SSS_UV_EN_MV);
  localparam logic [1:0]  UV_PERS   = 2'(`SSS_UV_PERSIST_TICKS);
  localparam logic [15:0] DIV_LAST  = 16'(OSC_DIV - 1);

  sss_pins_t        pins_raw;
  sss_pins_t        pins_s;
  logic [NSUP-1:0]  supply_s;

  sss_state_t       state_r, state_nxt;
  logic [15:0]      div_r, div_nxt;
  logic             tick_r, tick_nxt;
  logic [11:0]      cnt_r, cnt_nxt;
  logic [1:0]       uv_cnt_r, uv_cnt_nxt;
  logic             hs_seen_r, hs_seen_nxt;
  logic             uv_lat_r, uv_lat_nxt;
  logic             ov_lat_r, ov_lat_nxt;
  logic [NPH-1:0][15:0] lim_r, lim_nxt;
  logic [NPH-1:0][15:0] ton_r, ton_nxt;
  logic [NPH-1:0]   hs_nxt, ls_nxt;
  logic             oe_nxt, uv_en_nxt, done_nxt;
  logic [9:0]       ref_nxt;
  sss_margin_t      marg_nxt;
  logic             enable;
  logic             ov_hit, uv_hit;
  logic [21:0]      prod;
  logic [31:0]      lim_w;

  assign pins_raw = '{inhibit: inhibit_in, marg_a: margin_sel_a, marg_b: margin_sel_b,
                      op_mode: op_mode_in, uv_low: uv_cmp_in, ov_high: ov_cmp_in,
                      pg_low: pg_cmp_in};

  // Pin synchronisers
  sss_sync #(.WIDTH($bits(sss_pins_t))) u_sync_pins (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .async_in (pins_raw),
    .sync_out (pins_s)
  );

  sss_sync #(.WIDTH(NSUP)) u_sync_sup (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .async_in (supply_ok_in),
    .sync_out (supply_s)
  );

  // Sequencer, ramp, protections and drive gating
  always_comb begin
    enable      = (&supply_s) && !pins_s.inhibit;          // [R5]
    div_nxt     = (div_r == DIV_LAST) ? 16'h0000 : div_r + 16'h0001;
    tick_nxt    = (div_r == DIV_LAST);
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    uv_cnt_nxt  = uv_cnt_r;
    hs_seen_nxt = hs_seen_r;
    uv_lat_nxt  = uv_lat_r;
    ov_lat_nxt  = ov_lat_r;
    uv_en_nxt   = uv_enable;
    ov_hit      = 1'b0;
    uv_hit      = 1'b0;
    unique case (state_r)
      SSS_IDLE: begin
        cnt_nxt     = 12'h000;                              // [R13]
        hs_seen_nxt = 1'b0;
        uv_lat_nxt  = 1'b0;
        ov_lat_nxt  = 1'b0;
        uv_cnt_nxt  = 2'h0;
        if (enable) begin
          state_nxt = SSS_RAMP;                             // [R5]
        end
      end
      SSS_RAMP, SSS_RUN: begin
        if (|hs_cmd) begin
          hs_seen_nxt = 1'b1;                               // [R6]
        end
        if (state_r == SSS_RAMP && tick_r) begin
          cnt_nxt = cnt_r + 12'h001;                        // [R1]
          if (cnt_nxt == RAMP_END) begin
            state_nxt = SSS_RUN;                            // [R1]
          end
        end
        // Persistence of the undervoltage comparator in oscillator ticks
        if (tick_r) begin
          if (pins_s.uv_low && uv_enable) begin
            uv_cnt_nxt = (uv_cnt_r == UV_PERS) ? uv_cnt_r : uv_cnt_r + 2'h1;
          end else begin
            uv_cnt_nxt = 2'h0;
          end
        end
        uv_hit = (uv_cnt_nxt == UV_PERS);                   // [R10]
        ov_hit = pins_s.ov_high;                            // [R4]
        if (ov_hit) begin
          ov_lat_nxt = 1'b1;                                // [R11]
          state_nxt  = SSS_FAULT;
        end else if (uv_hit) begin
          uv_lat_nxt = 1'b1;                                // [R10]
          state_nxt  = SSS_FAULT;
        end
      end
      SSS_FAULT: begin
        state_nxt = SSS_FAULT;                              // [R10] [R11]
      end
      default: begin
        state_nxt = SSS_IDLE;
      end
    endcase
    // A restart also drops the latched faults, so a short inhibit pulse
    // cannot leave a stale latch behind in idle
    if (!enable) begin
      state_nxt  = SSS_IDLE;                                // [R13]
      cnt_nxt    = 12'h000;
      uv_lat_nxt = 1'b0;                                    // [R13]
      ov_lat_nxt = 1'b0;                                    // [R13]
    end
    // Reference follows the ramp count
    prod    = 22'(TARGET_MV) * 22'(cnt_nxt);
    ref_nxt = (state_nxt == SSS_RUN) ? TARGET_MV : prod[20:11]; // [R1]
    if (state_nxt == SSS_RAMP) begin
      uv_en_nxt = (ref_nxt >= UV_EN_MV);                    // [R3]
    end else begin
      uv_en_nxt = (state_nxt == SSS_RUN);
    end
    done_nxt = (state_nxt == SSS_RUN);
    oe_nxt   = !(state_nxt == SSS_RUN) || pins_s.pg_low;   // [R2] [R12]
    // Margining decode
    unique case ({pins_s.marg_a, pins_s.marg_b})
      2'b10:   marg_nxt = SSS_MARG_NONE;                    // [R9]
      2'b00:   marg_nxt = SSS_MARG_POS;                     // [R9]
      2'b01:   marg_nxt = SSS_MARG_NEG;                     // [R9]
      default: marg_nxt = SSS_MARG_NONE;
    endcase
    // Per-phase on-time limit and gate drives
    lim_w = 32'h0;
    for (int p = 0; p < NPH; p++) begin
      lim_w = (32'(OSC_DIV) * (32'(`SSS_TON_ZERO_PCT * `SSS_CUR_FULL_SCALE)
              - 32'(`SSS_TON_ZERO_PCT - `SSS_TON_FS_PCT) * 32'(phase_cur[p])))
              / 32'(100 * `SSS_CUR_FULL_SCALE);
      lim_nxt[p] = lim_w[15:0];                             // [R8]
      ton_nxt[p] = (hs_cmd[p] && ton_r[p] != 16'hffff) ? ton_r[p] + 16'h0001 : 16'h0000;
      hs_nxt[p]  = 1'b0;
      ls_nxt[p]  = 1'b0;
      if (ov_lat_nxt) begin
        ls_nxt[p] = 1'b1;                                   // [R7] [R11]
      end else if (state_nxt == SSS_RAMP || state_nxt == SSS_RUN) begin
        hs_nxt[p] = hs_cmd[p] && (ton_r[p] < lim_r[p]);     // [R8]
        ls_nxt[p] = ls_cmd[p] && !hs_cmd[p] && hs_seen_nxt; // [R6]
      end
    end
  end

  // State registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r           <= SSS_IDLE;
      div_r             <= 16'h0000;
      tick_r            <= 1'b0;
      cnt_r             <= 12'h000;
      uv_cnt_r          <= 2'h0;
      hs_seen_r         <= 1'b0;
      uv_lat_r          <= 1'b0;
      ov_lat_r          <= 1'b0;
      lim_r             <= '0;
      ton_r             <= '0;
      high_side_drive   <= '0;
      low_side_drive    <= '0;
      power_ok_out      <= 1'b0;
      power_ok_oe       <= 1'b1;
      fault_out         <= 1'b0;
      undervoltage_trip <= 1'b0;
      overvoltage_trip  <= 1'b0;
      uv_enable         <= 1'b0;
      ov_level_sel      <= 1'b0;
      ramp_done         <= 1'b0;
      ref_mv            <= 10'h000;
      margin_mode       <= SSS_MARG_NONE;
    end else begin
      state_r           <= state_nxt;
      div_r             <= div_nxt;
      tick_r            <= tick_nxt;
      cnt_r             <= cnt_nxt;
      uv_cnt_r          <= uv_cnt_nxt;
      hs_seen_r         <= hs_seen_nxt;
      uv_lat_r          <= uv_lat_nxt;
      ov_lat_r          <= ov_lat_nxt;
      lim_r             <= lim_nxt;
      ton_r             <= ton_nxt;
      high_side_drive   <= hs_nxt;
      low_side_drive    <= ls_nxt;
      power_ok_out      <= 1'b0;
      power_ok_oe       <= oe_nxt;
      fault_out         <= uv_lat_nxt || ov_lat_nxt;
      undervoltage_trip <= uv_lat_nxt;
      overvoltage_trip  <= ov_lat_nxt;
      uv_enable         <= uv_en_nxt;
      ov_level_sel      <= pins_s.op_mode;                  // [R4]
      ramp_done         <= done_nxt;
      ref_mv            <= ref_nxt;
      margin_mode       <= marg_nxt;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  ramp_length_a: assert property (state_r == SSS_RAMP && tick_r && cnt_r == 12'h7ff
    && enable && !ov_hit && !uv_hit |=> state_r == SSS_RUN && ref_mv == TARGET_MV) // [R1]
    else $error("ramp did not end at 2048 ticks");
  ramp_early_a: assert property (state_r == SSS_RUN && $past(state_r) == SSS_RAMP
    |-> $past(cnt_r) == 12'h7ff) // [R1]
    else $error("ramp ended early");
  pg_held_a: assert property (state_r == SSS_RAMP |-> power_ok_oe) // [R2]
    else $error("power good released during ramp");
  uv_early_a: assert property (state_r == SSS_RAMP && ref_mv < UV_EN_MV |-> !uv_enable) // [R3]
    else $error("undervoltage enabled early");
  ov_force_a: assert property (ov_lat_r |-> low_side_drive == '1
    && high_side_drive == '0 && fault_out) // [R7] [R11]
    else $error("overvoltage did not force drives");
  ov_catch_a: assert property (state_r == SSS_RAMP && pins_s.ov_high && enable
    |=> overvoltage_trip) // [R4]
    else $error("overvoltage missed during ramp");
  no_start_a: assert property (!enable |=> state_r == SSS_IDLE) // [R5]
    else $error("sequence left idle without enable");
  ls_mask_a: assert property (state_r == SSS_RAMP && !hs_seen_r && !ov_lat_r
    && !pins_s.ov_high && !(|hs_cmd) |=> !(|low_side_drive)) // [R6]
    else $error("low side driven before high side");
  uv_latch_a: assert property (uv_lat_r && enable |=> uv_lat_r && high_side_drive == '0
    && low_side_drive == '0) // [R10]
    else $error("undervoltage latch lost");
  restart_a: assert property (state_r == SSS_IDLE |-> cnt_r == 12'h000 ##1 power_ok_oe) // [R13]
    else $error("restart did not clear ramp");

  ramp_done_c: cover property (state_r == SSS_RAMP ##1 state_r == SSS_RUN);
  ov_trip_c:   cover property (state_r == SSS_RAMP ##1 ov_lat_r);
  uv_trip_c:   cover property (state_r == SSS_RUN ##1 uv_lat_r);
  restart_c:   cover property (state_r == SSS_FAULT ##1 state_r == SSS_IDLE);

endmodule

`default_nettype wire

/* File: verif/soft_start_sequencer_tb.sv */
`timescale 1ns/1ns
`default_nettype none

module soft_start_sequencer_tb import sss_pkg::*;;
  logic            sys_clk = 1'b0;
  logic            reset_n = 1'b0;
  logic [1:0]      supply_ok_in = 2'h0;
  logic            inhibit_in = 1'h1;
  logic [1:0]      marg_req = 2'h0;
  logic            op_mode_in = 1'h1;
  logic            uv_cmp_in = 1'h0;
  logic            ov_cmp_in = 1'h0;
  logic            pg_cmp_in = 1'h0;
  logic [2:0]      hs_cmd = 3'h0;
  logic [2:0]      ls_cmd = 3'h0;
  logic [2:0][7:0] phase_cur = '0;
  logic            margin_sel_a, margin_sel_b, shoot_thru, power_ok_out, power_ok_oe;
  logic            fault_out, undervoltage_trip, overvoltage_trip, uv_enable;
  logic            ov_level_sel, ramp_done;
  logic [2:0]      high_side_drive, low_side_drive;
  logic [9:0]      ref_mv;
  sss_margin_t     margin_mode;
  int              n_mismatch = 0;
  int              checks = 0;
  int              n, n0, nfs;
  // Rows: supplies, inhibit, margin request, ramp expected
  logic [5:0]      rows [6] = '{6'h31, 6'h12, 6'h24, 6'h3a, 6'h35, 6'h33};

  // Design and far-side model
  sss_top #(.OSC_DIV(8)) u_dut (
    .sys_clk, .reset_n, .supply_ok_in, .inhibit_in, .margin_sel_a, .margin_sel_b,
    .op_mode_in, .uv_cmp_in, .ov_cmp_in, .pg_cmp_in, .hs_cmd, .ls_cmd, .phase_cur,
    .high_side_drive, .low_side_drive, .power_ok_out, .power_ok_oe, .fault_out,
    .undervoltage_trip, .overvoltage_trip, .uv_enable, .ov_level_sel, .ramp_done,
    .ref_mv, .margin_mode
  );
  sss_ext_model u_ext (
    .sys_clk, .marg_req, .hs_gate(high_side_drive), .ls_gate(low_side_drive),
    .margin_sel_a, .margin_sel_b, .shoot_thru
  );

  // Clock
  always #5 sys_clk = ~sys_clk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic give_up;
    n_mismatch++;
    wrap_up();
  endtask

  task automatic wait_fault(input int lim);
    for (int i = 0; fault_out !== 1'b1; i++) begin
      if (i == lim) give_up();
      @(negedge sys_clk);
    end
  endtask

  // Hang guard
  initial begin
    #1000000;
    give_up();
  end

  // Main sequence
  initial begin
    repeat (12) @(negedge sys_clk);
    chk(16'(power_ok_oe), 16'h1);
    chk(16'({high_side_drive, low_side_drive}), 16'h0);
    chk(16'(power_ok_out), 16'h0);
    $display("reset test done");
    reset_n = 1'b1;
    // Start gating and margin decode
    foreach (rows[i]) begin
      {supply_ok_in, inhibit_in, marg_req} = rows[i][5:1];
      repeat (40) @(negedge sys_clk);
      chk(16'(ref_mv != 10'h0), 16'(rows[i][0]));
      chk(16'(margin_mode), 16'(marg_req));
      inhibit_in = 1'b1;
      repeat (10) @(negedge sys_clk);
      chk(16'(ref_mv), 16'h0);
      chk(16'({ramp_done, power_ok_oe}), 16'h1);
      $display("row %0d done", i);
    end
    // Full ramp, low-side mask lifted by one high-side pulse
    marg_req = 2'h0;
    ls_cmd = 3'h7;
    inhibit_in = 1'b0;
    for (n = 0; ramp_done !== 1'b1; n++) begin
      if (n == 17000) give_up();
      hs_cmd = (n == 4000) ? 3'h1 : 3'h0;
      if (n < 4000) chk(16'(low_side_drive), 16'h0);
      if (n > 4010) chk(16'(low_side_drive), 16'h7);
      chk(16'(power_ok_oe), 16'h1);
      if (ref_mv < 10'h258) chk(16'(uv_enable), 16'h0);
      @(negedge sys_clk);
    end
    // 2048 ticks of 8 cycles, 3 cycles of start latency, one tick of phase slack
    chk(16'(n >= 16380 && n <= 16387), 16'h1);
    chk(16'(ref_mv), 16'h320);
    repeat (2) @(negedge sys_clk);
    chk(16'({power_ok_out, power_ok_oe}), 16'h0);
    chk(16'(uv_enable), 16'h1);
    chk(16'(ov_level_sel), 16'h1);
    op_mode_in = 1'b0;
    repeat (5) @(negedge sys_clk);
    chk(16'(ov_level_sel), 16'h0);
    $display("ramp test done");
    // Power-good pulled low on a low output
    pg_cmp_in = 1'b1;
    repeat (5) @(negedge sys_clk);
    chk(16'(power_ok_oe), 16'h1);
    pg_cmp_in = 1'b0;
    repeat (5) @(negedge sys_clk);
    chk(16'(power_ok_oe), 16'h0);
    $display("power good test done");
    // On-time limit at zero and full-scale current
    ls_cmd = 3'h0;
    for (int k = 0; k < 2; k++) begin
      phase_cur = {3{k ? 8'hff : 8'h00}};
      hs_cmd = 3'h1;
      n = 0;
      repeat (12) begin
        @(negedge sys_clk);
        n += int'(high_side_drive[0] === 1'b1);
      end
      hs_cmd = 3'h0;
      repeat (3) @(negedge sys_clk);
      if (k == 1) nfs = n;
      else n0 = n;
    end
    chk(16'(n0 inside {[6:7]}), 16'h1);
    chk(16'(nfs inside {[3:4]}), 16'h1);
    $display("on-time test done");
    // Undervoltage latch, then restart by inhibit
    uv_cmp_in = 1'b1;
    wait_fault(40);
    chk(16'(undervoltage_trip), 16'h1);
    hs_cmd = 3'h7;
    ls_cmd = 3'h7;
    repeat (3) @(negedge sys_clk);
    chk(16'({high_side_drive, low_side_drive}), 16'h0);
    uv_cmp_in = 1'b0;
    hs_cmd = 3'h0;
    inhibit_in = 1'b1;
    repeat (10) @(negedge sys_clk);
    chk(16'({fault_out, undervoltage_trip, power_ok_oe}), 16'h1);
    chk(16'(ref_mv), 16'h0);
    $display("undervoltage test done");
    // Overvoltage while the low-side mask holds
    inhibit_in = 1'b0;
    repeat (50) @(negedge sys_clk);
    chk(16'(low_side_drive), 16'h0);
    ov_cmp_in = 1'b1;
    wait_fault(10);
    chk(16'({low_side_drive, high_side_drive}), 16'h38);
    chk(16'(overvoltage_trip), 16'h1);
    chk(16'(shoot_thru), 16'h0);
    $display("overvoltage test done");
    // Reset in mid-run clears the latch, then the fault comes back
    reset_n = 1'b0;
    @(negedge sys_clk);
    chk(16'({fault_out, overvoltage_trip, low_side_drive, power_ok_oe}), 16'h1);
    reset_n = 1'b1;
    wait_fault(10);
    chk(16'(overvoltage_trip), 16'h1);
    $display("mid-run reset test done");
    wrap_up();
  end
endmodule

`default_nettype wire

/* File: verif/sss_ext_model.sv */
`timescale 1ns/1ns
`default_nettype none

module sss_ext_model
  import sss_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic [1:0] marg_req,
  input  wire logic [2:0] hs_gate,
  input  wire logic [2:0] ls_gate,
  output logic            margin_sel_a,
  output logic            margin_sel_b,
  output logic            shoot_thru
);
  // Margin switch levels for the requested offset
  always_comb begin
    margin_sel_a = (marg_req == SSS_MARG_NONE);
    margin_sel_b = (marg_req == SSS_MARG_NEG);
  end

  // Sticky flag when one phase has both gates on
  initial shoot_thru = 1'b0;
  always @(posedge sys_clk) begin
    if (|(hs_gate & ls_gate)) begin
      shoot_thru <= 1'b1;
    end
  end
endmodule

`default_nettype wire
